/* rpos_consts.vh */
// Constants for the remappable pin output select block.
`ifndef RPOS_CONSTS_VH
`define RPOS_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RPOS_OFS_PIN2_PIN3     12'h004
`define RPOS_OFS_PIN5          12'h008
`define RPOS_OFS_PIN6_PIN7     12'h00C
`define RPOS_OFS_PIN8_PIN9     12'h010
`define RPOS_OFS_PIN10_PIN11   12'h014
`define RPOS_OFS_PIN13         12'h018
`define RPOS_OFS_PIN14_PIN15   12'h01C
`define RPOS_OFS_PIN16_PIN17   12'h020

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define RPOS_SEL_W             6
`define RPOS_HI_LSB            8
`define RPOS_HI_MSB            13
`define RPOS_LO_LSB            0
`define RPOS_LO_MSB            5
`define RPOS_SEL_RESET         6'h00
`define RPOS_FUNC_W            64
`define RPOS_NUM_PINS          14
`define RPOS_PKG_PIN_LSB       12
`define RPOS_RESP_OKAY         2'h0
`define RPOS_RESP_SLVERR       2'h2

`endif

/* rpos_output_select.v */
// Remappable pin output select: AXI4-Lite register file and pin routing.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`include "rpos_consts.vh"

module rpos_output_select (
   // Clock and reset
   input  wire        core_clk,
   input  wire        rst,
   // AXI4-Lite write address
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Package option
   input  wire        large_package,
   // Peripheral output functions
   input  wire [63:0] func_out,
   input  wire [63:0] func_oe,
   // Remappable pins, bit order 2,3,5,6,7,8,9,10,11,13,14,15,16,17
   output wire [13:0] remappable_pin_out,
   output wire [13:0] remappable_pin_oe
);

   // -------------------------------------------------------------------------
   // Selector storage
   // -------------------------------------------------------------------------
   reg  [5:0]  pin2_function_selector_reg;
   reg  [5:0]  pin3_function_selector_reg;
   reg  [5:0]  pin5_function_selector_reg;
   reg  [5:0]  pin6_function_selector_reg;
   reg  [5:0]  pin7_function_selector_reg;
   reg  [5:0]  pin8_function_selector_reg;
   reg  [5:0]  pin9_function_selector_reg;
   reg  [5:0]  pin10_function_selector_reg;
   reg  [5:0]  pin11_function_selector_reg;
   reg  [5:0]  pin13_function_selector_reg;
   reg  [5:0]  pin14_function_selector_reg;
   reg  [5:0]  pin15_function_selector_reg;
   reg  [5:0]  pin16_function_selector_reg;
   reg  [5:0]  pin17_function_selector_reg;

   // -------------------------------------------------------------------------
   // Write channel
   // -------------------------------------------------------------------------
   reg  [11:0] aw_addr_reg;
   reg         aw_held_reg;
   reg  [31:0] w_data_reg;
   reg  [3:0]  w_strb_reg;
   reg         w_held_reg;
   wire        do_write;
   wire        lo_en;
   wire        hi_en;
   reg         wr_hit;

   assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign lo_en    = w_strb_reg[0];
   assign hi_en    = w_strb_reg[1];

   // Only the eight register words answer; any other byte address gets an error response.
   always @* begin
      wr_hit = 1'b0;
      case (aw_addr_reg)
         `RPOS_OFS_PIN2_PIN3:   wr_hit = 1'b1;
         `RPOS_OFS_PIN5:        wr_hit = 1'b1;
         `RPOS_OFS_PIN6_PIN7:   wr_hit = 1'b1;
         `RPOS_OFS_PIN8_PIN9:   wr_hit = 1'b1;
         `RPOS_OFS_PIN10_PIN11: wr_hit = 1'b1;
         `RPOS_OFS_PIN13:       wr_hit = 1'b1;
         `RPOS_OFS_PIN14_PIN15: wr_hit = 1'b1;
         `RPOS_OFS_PIN16_PIN17: wr_hit = 1'b1;
         default:               wr_hit = 1'b0;
      endcase
   end

   always @(posedge core_clk) begin
      if (rst) begin
         aw_addr_reg   <= 12'h000;
         aw_held_reg   <= 1'b0;
         w_data_reg    <= 32'h00000000;
         w_strb_reg    <= 4'h0;
         w_held_reg    <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RPOS_RESP_OKAY;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         if (s_axi_awvalid && !aw_held_reg && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
            aw_held_reg <= 1'b1;
         end
         if (s_axi_wvalid && !w_held_reg && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            w_held_reg <= 1'b1;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `RPOS_RESP_OKAY : `RPOS_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Register updates
   // -------------------------------------------------------------------------
   always @(posedge core_clk) begin
      if (rst) begin
         pin2_function_selector_reg  <= `RPOS_SEL_RESET;
         pin3_function_selector_reg  <= `RPOS_SEL_RESET;
         pin5_function_selector_reg  <= `RPOS_SEL_RESET;
         pin6_function_selector_reg  <= `RPOS_SEL_RESET;
         pin7_function_selector_reg  <= `RPOS_SEL_RESET;
         pin8_function_selector_reg  <= `RPOS_SEL_RESET;
         pin9_function_selector_reg  <= `RPOS_SEL_RESET;
         pin10_function_selector_reg <= `RPOS_SEL_RESET;
         pin11_function_selector_reg <= `RPOS_SEL_RESET;
         pin13_function_selector_reg <= `RPOS_SEL_RESET;
         pin14_function_selector_reg <= `RPOS_SEL_RESET;
         pin15_function_selector_reg <= `RPOS_SEL_RESET;
         pin16_function_selector_reg <= `RPOS_SEL_RESET;
         pin17_function_selector_reg <= `RPOS_SEL_RESET;
      end else if (do_write) begin
         // Only the selector bits are stored; bits 31:14 and 7:6 are dropped.
         case (aw_addr_reg)
            `RPOS_OFS_PIN2_PIN3: begin
               if (lo_en) pin2_function_selector_reg <= w_data_reg[`RPOS_LO_MSB:`RPOS_LO_LSB];
               if (hi_en) pin3_function_selector_reg <= w_data_reg[`RPOS_HI_MSB:`RPOS_HI_LSB];
            end
            `RPOS_OFS_PIN5: begin
               if (hi_en) pin5_function_selector_reg <= w_data_reg[`RPOS_HI_MSB:`RPOS_HI_LSB];
            end
            `RPOS_OFS_PIN6_PIN7: begin
               if (lo_en) pin6_function_selector_reg <= w_data_reg[`RPOS_LO_MSB:`RPOS_LO_LSB];
               if (hi_en) pin7_function_selector_reg <= w_data_reg[`RPOS_HI_MSB:`RPOS_HI_LSB];
            end
            `RPOS_OFS_PIN8_PIN9: begin
               if (lo_en) pin8_function_selector_reg <= w_data_reg[`RPOS_LO_MSB:`RPOS_LO_LSB];
               if (hi_en) pin9_function_selector_reg <= w_data_reg[`RPOS_HI_MSB:`RPOS_HI_LSB];
            end
            `RPOS_OFS_PIN10_PIN11: begin
               if (lo_en) pin10_function_selector_reg <= w_data_reg[`RPOS_LO_MSB:`RPOS_LO_LSB];
               if (hi_en) pin11_function_selector_reg <= w_data_reg[`RPOS_HI_MSB:`RPOS_HI_LSB];
            end
            `RPOS_OFS_PIN13: begin
               if (hi_en) pin13_function_selector_reg <= w_data_reg[`RPOS_HI_MSB:`RPOS_HI_LSB];
            end
            `RPOS_OFS_PIN14_PIN15: begin
               if (lo_en) pin14_function_selector_reg <= w_data_reg[`RPOS_LO_MSB:`RPOS_LO_LSB];
               if (hi_en) pin15_function_selector_reg <= w_data_reg[`RPOS_HI_MSB:`RPOS_HI_LSB];
            end
            `RPOS_OFS_PIN16_PIN17: begin
               if (lo_en) pin16_function_selector_reg <= w_data_reg[`RPOS_LO_MSB:`RPOS_LO_LSB];
               if (hi_en) pin17_function_selector_reg <= w_data_reg[`RPOS_HI_MSB:`RPOS_HI_LSB];
            end
            default: begin
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Read words
   // -------------------------------------------------------------------------
   wire [31:0] pin2_pin3_word;
   wire [31:0] pin5_word;
   wire [31:0] pin6_pin7_word;
   wire [31:0] pin8_pin9_word;
   wire [31:0] pin10_pin11_word;
   wire [31:0] pin13_word;
   wire [31:0] pin14_pin15_word;
   wire [31:0] pin16_pin17_word;

   assign pin2_pin3_word   = {18'h0, pin3_function_selector_reg, 2'h0, pin2_function_selector_reg};
   assign pin5_word        = {18'h0, pin5_function_selector_reg, 8'h00};
   assign pin6_pin7_word   = {18'h0, pin7_function_selector_reg, 2'h0, pin6_function_selector_reg};
   assign pin8_pin9_word   = {18'h0, pin9_function_selector_reg, 2'h0, pin8_function_selector_reg};
   assign pin10_pin11_word = {18'h0, pin11_function_selector_reg, 2'h0, pin10_function_selector_reg};
   assign pin13_word       = {18'h0, pin13_function_selector_reg, 8'h00};
   assign pin14_pin15_word = {18'h0, pin15_function_selector_reg, 2'h0, pin14_function_selector_reg};
   assign pin16_pin17_word = {18'h0, pin17_function_selector_reg, 2'h0, pin16_function_selector_reg};

   // -------------------------------------------------------------------------
   // Read channel
   // -------------------------------------------------------------------------
   reg  [31:0] rd_word;
   reg         rd_hit;

   always @* begin
      rd_word = 32'h00000000;
      rd_hit  = 1'b1;
      case (s_axi_araddr)
         `RPOS_OFS_PIN2_PIN3:   rd_word = pin2_pin3_word;
         `RPOS_OFS_PIN5:        rd_word = pin5_word;
         `RPOS_OFS_PIN6_PIN7:   rd_word = pin6_pin7_word;
         `RPOS_OFS_PIN8_PIN9:   rd_word = pin8_pin9_word;
         `RPOS_OFS_PIN10_PIN11: rd_word = pin10_pin11_word;
         `RPOS_OFS_PIN13:       rd_word = pin13_word;
         `RPOS_OFS_PIN14_PIN15: rd_word = pin14_pin15_word;
         `RPOS_OFS_PIN16_PIN17: rd_word = pin16_pin17_word;
         default:               rd_hit  = 1'b0;
      endcase
   end

   always @(posedge core_clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RPOS_RESP_OKAY;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? `RPOS_RESP_OKAY : `RPOS_RESP_SLVERR;
            s_axi_rvalid  <= 1'b1;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Pin routing
   // -------------------------------------------------------------------------
   wire [83:0] sel_bus;
   wire [63:0] func_oe_large;

   assign sel_bus = {pin17_function_selector_reg, pin16_function_selector_reg,
                     pin15_function_selector_reg, pin14_function_selector_reg,
                     pin13_function_selector_reg, pin11_function_selector_reg,
                     pin10_function_selector_reg, pin9_function_selector_reg,
                     pin8_function_selector_reg,  pin7_function_selector_reg,
                     pin6_function_selector_reg,  pin5_function_selector_reg,
                     pin3_function_selector_reg,  pin2_function_selector_reg};

   // The pin 16/17 pads are absent on the small package, so their enables are masked
   // ahead of the pin flop and the mask takes effect one cycle after the input changes.
   assign func_oe_large = func_oe & {64{large_package}};

   genvar gi;
   generate
      for (gi = 0; gi < `RPOS_NUM_PINS; gi = gi + 1) begin : g_pin
         if (gi < `RPOS_PKG_PIN_LSB) begin : g_all_pkg
            rpos_pin_mux u_mux (
               .core_clk (core_clk),
               .rst      (rst),
               .sel      (sel_bus[gi*6+5:gi*6]),
               .func_out (func_out),
               .func_oe  (func_oe),
               .pin_out  (remappable_pin_out[gi]),
               .pin_oe   (remappable_pin_oe[gi])
            );
         end else begin : g_large_pkg
            rpos_pin_mux u_mux (
               .core_clk (core_clk),
               .rst      (rst),
               .sel      (sel_bus[gi*6+5:gi*6]),
               .func_out (func_out),
               .func_oe  (func_oe_large),
               .pin_out  (remappable_pin_out[gi]),
               .pin_oe   (remappable_pin_oe[gi])
            );
         end
      end
   endgenerate

endmodule

/* rpos_output_select_props.sv */
// Concurrent checks on the ports of the remappable pin output select block.
module rpos_output_select_props (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        rst,
   // Bus
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Pins
   input wire logic        large_package,
   input wire logic [63:0] func_out,
   input wire logic [63:0] func_oe,
   input wire logic [13:0] remappable_pin_out,
   input wire logic [13:0] remappable_pin_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   AST_RSVD_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:14] == 18'h0 && s_axi_rdata[7:6] == 2'h0)
      else $error("reserved read bits not zero");
   AST_RESET_CLEAR: assert property (disable iff (1'b0) rst |=> remappable_pin_out == 14'h0 &&
      remappable_pin_oe == 14'h0 && !s_axi_bvalid && !s_axi_rvalid) else $error("reset did not clear outputs");
   AST_SMALL_PKG: assert property (!large_package |=> remappable_pin_oe[13:12] == 2'h0)
      else $error("pins 16 and 17 driven on small package");
   AST_PIN_HOLD: assert property (($stable(func_out) && $stable(func_oe) && $stable(s_axi_bvalid))[*3]
      |=> $stable(remappable_pin_out)) else $error("pin changed without a write");
   AST_AWREADY_PULSE: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready longer than a cycle");
   AST_AW_REFUSED: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write address taken during response");
   AST_AR_ANSWER: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
      else $error("read not answered in one cycle");
   AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid held after handshake");
   AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid held after handshake");
endmodule
bind rpos_output_select rpos_output_select_props rpos_output_select_props_i (.core_clk, .rst, .s_axi_awready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .large_package, .func_out, .func_oe, .remappable_pin_out, .remappable_pin_oe);

/* rpos_periph_model.sv */
// Behavioural model of the peripheral output functions that feed the pins.
module rpos_periph_model (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Freezes the pattern while pins are judged
   input  wire logic        hold,
   // Peripheral output functions
   output logic      [63:0] func_out,
   output logic      [63:0] func_oe
);
   // Each unfrozen cycle moves every function, so a wrong selection shows up.
   always @(posedge core_clk) begin
      if (rst) begin
         func_out <= 64'hA5C3_0F96_5A3C_F069;
         func_oe  <= 64'h3C96_A50F_C369_5AF0;
      end else if (!hold) begin
         func_out <= {func_out[62:0], func_out[63]};
         func_oe  <= {func_oe[0], func_oe[63:1]};
      end
   end
endmodule

/* rpos_pin_mux.v */
// One remappable pin: registered selection of a peripheral output function.
module rpos_pin_mux (
   // Clock and reset
   input  wire        core_clk,
   input  wire        rst,
   // Selection
   input  wire [5:0]  sel,
   input  wire [63:0] func_out,
   input  wire [63:0] func_oe,
   // Pin
   output reg         pin_out,
   output reg         pin_oe
);

   always @(posedge core_clk) begin
      if (rst) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else if (sel == 6'h00) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else begin
         pin_out <= func_out[sel];
         pin_oe  <= func_oe[sel];
      end
   end

endmodule

/* tb_top.sv */
// Self-checking bench for the remappable pin output select block.
`include "rpos_consts.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk = 1'b0, rst = 1'b1, hold = 1'b1, large_package = 1'b1;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [63:0] func_out, func_oe;
   wire  [13:0] remappable_pin_out, remappable_pin_oe;
   int          n_mismatch = 0, checked = 0, cycles = 0;
   localparam logic [11:0] OFS [8] = '{`RPOS_OFS_PIN2_PIN3, `RPOS_OFS_PIN5, `RPOS_OFS_PIN6_PIN7, `RPOS_OFS_PIN8_PIN9,
      `RPOS_OFS_PIN10_PIN11, `RPOS_OFS_PIN13, `RPOS_OFS_PIN14_PIN15, `RPOS_OFS_PIN16_PIN17};
   // Pin index of the low and high selector of each register; -1 marks an absent field.
   localparam int LO [8] = '{0, -1, 3, 5, 7, -1, 10, 12};
   localparam int HI [8] = '{1, 2, 4, 6, 8, 9, 11, 13};
   rpos_output_select rpos_output_select_i (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .large_package, .func_out, .func_oe, .remappable_pin_out, .remappable_pin_oe);
   rpos_periph_model rpos_periph_model_i (.core_clk, .rst, .hold, .func_out, .func_oe);
   always #50 core_clk = ~core_clk;
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic cmp_resp(input string what, input logic [1:0] e, input logic [1:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic aw = 1'b0, w = 1'b0;
      @(posedge core_clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      while (!(aw && w)) begin
         @(posedge core_clk);
         aw = aw | (s_axi_awready === 1'b1);
         w = w | (s_axi_wready === 1'b1);
         s_axi_awvalid <= !aw;
         s_axi_wvalid <= !w;
      end
      while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
      s_axi_bready <= 1'b0;
      cmp_resp($sformatf("bresp %h", a), er, s_axi_bresp);
   endtask
   task automatic axi_read(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do @(posedge core_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
      s_axi_rready <= 1'b0;
      cmp_word($sformatf("rdata %h", a), e, s_axi_rdata);
      cmp_resp($sformatf("rresp %h", a), er, s_axi_rresp);
   endtask
   task automatic t_reset();
      for (int r = 0; r < 8; r++) axi_read(OFS[r], 32'h0, `RPOS_RESP_OKAY);
      axi_read(12'h000, 32'h0, `RPOS_RESP_SLVERR);
      cmp_word("pins", 32'h0, {2'b0, remappable_pin_oe, 2'b0, remappable_pin_out});
   endtask
   // Selectors per pass: distinct non-zero values, then a reversed set, then all zero.
   task automatic t_routing(input int p, input logic pkg);
      logic [5:0]  s [14];
      logic [13:0] eo, ee;
      for (int i = 0; i < 14; i++) s[i] = (p == 0) ? 6'(1 + 4 * i) : (p == 1) ? 6'(63 - i) : 6'h00;
      large_package <= pkg;
      hold <= 1'b0;
      repeat (3) @(posedge core_clk);
      hold <= 1'b1;
      for (int r = 0; r < 8; r++)
         axi_write(OFS[r], {16'hFFFF, 2'b11, s[HI[r]], 2'b11, (LO[r] < 0) ? 6'h3F : s[LO[r]]}, 4'hF, 2'h0);
      @(negedge core_clk);
      for (int i = 0; i < 14; i++) begin
         eo[i] = (s[i] != 6'h00) & func_out[s[i]];
         ee[i] = (s[i] != 6'h00) & func_oe[s[i]] & (i < 12 || pkg);
      end
      cmp_word("pins", {2'b0, ee, 2'b0, eo}, {2'b0, remappable_pin_oe, 2'b0, remappable_pin_out});
      for (int r = 0; r < 8; r++)
         axi_read(OFS[r], {18'h0, s[HI[r]], 2'b0, (LO[r] < 0) ? 6'h00 : s[LO[r]]}, `RPOS_RESP_OKAY);
   endtask
   task automatic t_strobe();
      axi_write(OFS[0], 32'h0000_0125, 4'h1, `RPOS_RESP_OKAY);
      axi_read(OFS[0], 32'h0000_0525, `RPOS_RESP_OKAY);
      axi_write(12'h024, 32'h0000_3F3F, 4'hF, `RPOS_RESP_SLVERR);
      axi_write(12'h006, 32'h0000_3F3F, 4'hF, `RPOS_RESP_SLVERR);
      axi_read(OFS[0], 32'h0000_0525, `RPOS_RESP_OKAY);
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_routing(0, 1'b1);
      t_strobe();
      t_routing(1, 1'b0);
      t_routing(2, 1'b1);
      complete_run();
   end
endmodule
